/* include/charge_pkg.sv */
package charge_pkg;
    // state encoding of the charge sequencer
    typedef enum logic [2:0] {
        st_disabled = 3'b000,
        st_trickle  = 3'b001,
        st_fast     = 3'b010,
        st_complete = 3'b011,
        st_fault    = 3'b100
    } charge_state_t;

    // charge timer geometry
    localparam int timer_width = 22;
    localparam int timeout_exp = 22;
    localparam logic [timer_width-1:0] timer_zero = 22'h000000;
    localparam logic [timer_width-1:0] timer_full_last = 22'h3FFFFF;
    // one eighth of the full count, minus one
    localparam logic [timer_width-1:0] timer_trickle_last = 22'h07FFFF;
    localparam int osc_div_width = 16;
    localparam logic [osc_div_width-1:0] osc_div_default = 16'h01F3;
    localparam logic [osc_div_width-1:0] osc_div_zero = 16'h0000;

    // register offsets
    localparam logic [3:0] reg_ctrl = 4'h0;
    localparam logic [3:0] reg_state = 4'h4;
    localparam logic [3:0] reg_irq_status = 4'h8;
    localparam logic [3:0] reg_irq_mask = 4'hC;

    // control register fields
    localparam int ctrl_enable_bit = 0;
    localparam int ctrl_timeout_gate_bit = 1;
    localparam logic [1:0] ctrl_reset_value = 2'h2;

    // interrupt status field positions
    localparam int irq_fault_bit = 0;
    localparam int irq_eoc_bit = 1;
    localparam int irq_recharge_bit = 2;
    localparam int irq_temp_bit = 3;
    localparam int irq_width = 4;
    localparam logic [irq_width-1:0] irq_zero = 4'h0;
endpackage

/* verilog/charge_timer.sv */
`timescale 1ns/100ps
module charge_timer (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // control
    input wire logic clear,
    input wire logic count_en,
    input wire logic [charge_pkg::osc_div_width-1:0] osc_div,
    // outputs
    output logic osc_tick,
    output logic osc_half,
    output logic [charge_pkg::timer_width-1:0] count
);
    import charge_pkg::*;
    logic [osc_div_width-1:0] div_q;
    logic [timer_width-1:0] count_q;
    wire div_wrap = (div_q >= osc_div);
    wire run_tick = count_en && div_wrap;

    // prescaler models the internal oscillator period
    always_ff @(posedge clock) begin
        if (!reset_n || clear || div_wrap) begin
            div_q <= osc_div_zero;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // timer counts oscillator periods, frozen while paused
    always_ff @(posedge clock) begin
        if (!reset_n || clear) begin
            count_q <= timer_zero;
        end else if (run_tick && count_q != timer_full_last) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign osc_tick = div_wrap;
    assign osc_half = (div_q == (osc_div >> 1)); // mid-period sample point
    assign count = count_q;
endmodule

/* verilog/charge_cycle_sequencer.sv */
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module charge_cycle_sequencer
    import charge_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // analog comparator inputs
    input wire logic precond_reached,
    input wire logic eoc_reached,
    input wire logic below_recharge,
    input wire logic temp_in_window,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // charger controls
    output logic charge_on,
    output logic trickle_mode,
    // open-drain indications, enable high while pulling low
    output logic status_oe,
    output logic fault_oe,
    output logic status_o,
    output logic fault_o,
    // interrupt
    output logic irq
);
    import charge_pkg::*;

    charge_state_t state_q, state_d;
    logic [1:0] ctrl_q;
    logic enable_prev_q;
    logic [irq_width-1:0] irq_status_q, irq_mask_q;
    logic [31:0] dat_q;
    logic ack_q;
    logic charge_q, trickle_q, status_oe_q, fault_oe_q, irq_q;
    logic done_ind_q, done_pend_q;
    logic [osc_div_width-1:0] osc_div_q;
    logic osc_tick;
    logic osc_half;
    logic [timer_width-1:0] timer_count;

    // bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    // writes land at the edge that samples ack high, as the master expects
    wire bus_wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
    wire wr_ctrl = bus_wr && (wb_adr_i == reg_ctrl);
    wire wr_status = bus_wr && (wb_adr_i == reg_irq_status);
    wire wr_mask = bus_wr && (wb_adr_i == reg_irq_mask);

    // control bits seen by the sequencer
    wire enable = ctrl_q[ctrl_enable_bit];
    wire timeout_gate_input = ctrl_q[ctrl_timeout_gate_bit];
    wire enable_toggled = enable != enable_prev_q;
    wire temp_bad = !temp_in_window;

    // timer limits
    wire trickle_expired = (timer_count >= timer_trickle_last) && osc_tick;
    wire fast_expired = (timer_count == timer_full_last) && osc_tick;
    wire in_charge = (state_q == st_trickle) || (state_q == st_fast)
        || (state_q == st_complete);
    wire timer_run = in_charge && !temp_bad;
    wire enter_trickle = (state_d == st_trickle) && (state_q != st_trickle);
    wire enter_fast = (state_d == st_fast) && (state_q != st_fast);
    wire timer_clear = enter_trickle || enter_fast;

    // next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            st_disabled: begin
                if (enable) begin
                    state_d = st_trickle;
                end
            end
            st_trickle: begin
                if (!enable) begin
                    state_d = st_disabled;
                end else if (temp_bad) begin
                    state_d = st_trickle;
                end else if (precond_reached) begin
                    state_d = st_fast;
                end else if (trickle_expired) begin
                    state_d = st_fault;
                end
            end
            st_fast: begin
                if (!enable) begin
                    state_d = st_disabled;
                end else if (temp_bad) begin
                    state_d = st_fast;
                end else if (eoc_reached) begin
                    state_d = st_complete;
                end else if (fast_expired && timeout_gate_input) begin
                    state_d = st_fault;
                end
            end
            st_complete: begin
                if (!enable) begin
                    state_d = st_disabled;
                end
            end
            st_fault: begin
                if (enable_toggled) begin
                    state_d = st_disabled;
                end
            end
            default: state_d = st_disabled;
        endcase
    end

    // state register; reset stands in for power-on
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= st_disabled;
        end else begin
            state_q <= state_d;
        end
    end

    // enable history; resets to the enable reset level, so no false toggle
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            enable_prev_q <= 1'b0;
        end else begin
            enable_prev_q <= enable;
        end
    end

    // done and recharge sampled mid-period, shown at the next tick
    wire in_complete = (state_q == st_complete);
    wire done_want = in_complete && !below_recharge;
    always_ff @(posedge clock) begin
        if (!reset_n || !in_complete) begin
            done_pend_q <= 1'b0;
        end else if (osc_half) begin
            done_pend_q <= done_want;
        end
    end

    // half a period from sample to tick gives 0.5 to 1.5 periods of delay
    always_ff @(posedge clock) begin
        if (!reset_n || !in_complete) begin
            done_ind_q <= 1'b0;
        end else if (osc_tick) begin
            done_ind_q <= done_pend_q;
        end
    end
    wire status_rise = in_complete && done_pend_q && osc_tick && !done_ind_q;
    wire recharge_fall = in_complete && done_ind_q && osc_tick && !done_pend_q;

    // next values of the output flops
    wire charge_d = in_charge && !temp_bad;
    wire fault_d = (state_q == st_fault) || (in_charge && temp_bad);
    wire trickle_d = (state_q == st_trickle) && !temp_bad;
    wire status_oe_d = charge_d && !done_ind_q;
    wire irq_d = |(irq_status_q & irq_mask_q);

    // charge current enable
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            charge_q <= 1'b0;
        end else begin
            charge_q <= charge_d;
        end
    end

    // trickle indication, dropped while paused
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            trickle_q <= 1'b0;
        end else begin
            trickle_q <= trickle_d;
        end
    end

    // status pull-down; released while done is shown
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            status_oe_q <= 1'b0;
        end else begin
            status_oe_q <= status_oe_d;
        end
    end

    // fault pull-down
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fault_oe_q <= 1'b0;
        end else begin
            fault_oe_q <= fault_d;
        end
    end

    // interrupt level, one cycle behind the status word
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // events
    wire [irq_width-1:0] irq_events = {
        in_charge && temp_bad,
        recharge_fall,
        status_rise,
        (state_d == st_fault) && (state_q != st_fault)
    };
    wire [irq_width-1:0] irq_clear = wr_status ? wb_dat_i[irq_width-1:0] : irq_zero;

    // per-bit next value; a set in the clearing cycle wins
    wire [irq_width-1:0] irq_status_d;
    genvar gi;
    generate
        for (gi = 0; gi < irq_width; gi++) begin : g_irq
            assign irq_status_d[gi] = irq_events[gi] || (irq_status_q[gi] && !irq_clear[gi]);
        end
    endgenerate

    // sticky status word
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            irq_status_q <= irq_zero;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    // control word; reset leaves the charger off with the fast timeout armed
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ctrl_q <= ctrl_reset_value;
        end else if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[ctrl_timeout_gate_bit:ctrl_enable_bit];
        end
    end

    // interrupt mask, same layout as the status word
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            irq_mask_q <= irq_zero;
        end else if (wr_mask) begin
            irq_mask_q <= wb_dat_i[irq_width-1:0];
        end
    end

    // oscillator divider; fixed, not visible to software
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            osc_div_q <= osc_div_default;
        end
    end

    // read mux; unmapped offsets read zero
    wire [31:0] rd_data =
        (wb_adr_i == reg_ctrl) ? {30'h0, ctrl_q} :
        (wb_adr_i == reg_state) ? {28'h0, done_ind_q, state_q} :
        (wb_adr_i == reg_irq_status) ? {28'h0, irq_status_q} :
        (wb_adr_i == reg_irq_mask) ? {28'h0, irq_mask_q} : 32'h0;

    // single wait-free answer, dropped the cycle after
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= bus_req;
            dat_q <= bus_req ? rd_data : 32'h0;
        end
    end

    charge_timer timer_i (
        .clock(clock),
        .reset_n(reset_n),
        .clear(timer_clear),
        .count_en(timer_run),
        .osc_div(osc_div_q),
        .osc_tick(osc_tick),
        .osc_half(osc_half),
        .count(timer_count)
    );

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign charge_on = charge_q;
    assign trickle_mode = trickle_q;
    assign status_oe = status_oe_q;
    assign fault_oe = fault_oe_q;
    assign status_o = 1'b0;
    assign fault_o = 1'b0;
    assign irq = irq_q;
endmodule

/* test/charge_host_model.sv */
`timescale 1ns/100ps
module charge_host_model (
    // open-drain enables from the charger
    input wire logic status_oe,
    input wire logic fault_oe,
    // host view of the lines, pulled up
    output logic status_line,
    output logic fault_line
);
    // released lines float to the pull-up level, never the last value
    assign status_line = status_oe ? 1'b0 : 1'b1;
    assign fault_line = fault_oe ? 1'b0 : 1'b1;
endmodule

/* test/charge_chk.sv */
`timescale 1ns/100ps
module charge_chk (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // watched inputs
    input wire logic precond_reached,
    input wire logic temp_in_window,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    // watched outputs
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic charge_on,
    input wire logic trickle_mode,
    input wire logic status_oe,
    input wire logic fault_oe,
    input wire logic status_o,
    input wire logic fault_o
);
    // single domain, so clock and reset are shared
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_rst_quiet; $rose(reset_n) |-> !charge_on && !status_oe && !fault_oe; endproperty
    property p_od_data; status_o == 1'b0 && fault_o == 1'b0; endproperty
    property p_temp_pause; !temp_in_window [*2] |-> !charge_on; endproperty
    property p_temp_fault; charge_on && !temp_in_window |-> ##[1:3] fault_oe; endproperty
    property p_fault_off; fault_oe [*2] |-> !charge_on; endproperty
    property p_pre_exit;
        trickle_mode && precond_reached && temp_in_window |-> ##[1:3] !trickle_mode;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
    a_rst_quiet: assert property (p_rst_quiet) else $error("output after reset");
    a_od_data: assert property (p_od_data) else $error("drain data high");
    a_temp_pause: assert property (p_temp_pause) else $error("charge in bad temp");
    a_temp_fault: assert property (p_temp_fault) else $error("no temp fault");
    a_fault_off: assert property (p_fault_off) else $error("charge in fault");
    a_pre_exit: assert property (p_pre_exit) else $error("trickle stuck");
    // main scenarios reached
    c_trickle: cover property ($rose(trickle_mode));
    c_done: cover property ($fell(status_oe) && charge_on);
    c_fault: cover property ($rose(fault_oe));
endmodule

/* test/charge_cycle_sequencer_tb_top.sv */
`timescale 1ns/100ps
module charge_cycle_sequencer_tb_top;
    import charge_pkg::*;
    logic clock, reset_n, pre, eoc, blw, tmp, cyc, stb, we, ack;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, r, d, s;
    logic con, trk, s_oe, f_oe, s_o, f_o, irq, s_ln, f_ln;
    logic [1:0] ce;
    int failures = 0;
    int tests_run = 0;
    charge_cycle_sequencer uut (.clock(clock), .reset_n(reset_n),
        .precond_reached(pre), .eoc_reached(eoc), .below_recharge(blw),
        .temp_in_window(tmp), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .charge_on(con), .trickle_mode(trk), .status_oe(s_oe),
        .fault_oe(f_oe), .status_o(s_o), .fault_o(f_o), .irq(irq));
    charge_host_model host (.status_oe(s_oe), .fault_oe(f_oe),
        .status_line(s_ln), .fault_line(f_ln));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            failures++;
        end
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] m,
        input logic [31:0] v);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= m;
        wdat <= v;
        do @(posedge clock); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    function automatic logic [31:0] st_word(charge_state_t st, logic done);
        return {28'h0, done, st};
    endfunction
    task automatic summarize();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // cut a hang well beyond the ~2000 cycles of the sequence
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        summarize();
    end
    initial begin
        {reset_n, pre, eoc, blw, cyc, stb, we} <= 7'h0;
        {tmp, adr, sel, wdat} <= {1'b1, 40'h0};
        void'($urandom(32'hFA5C));
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        wb(0, reg_ctrl, 4'hF, 0); chk(r, 32'h2);
        wb(0, reg_state, 4'hF, 0); chk(r, st_word(st_disabled, 0));
        wb(0, 4'h2, 4'hF, 0); chk(r, 32'h0);
        wb(1, reg_irq_mask, 4'hF, 32'hF);
        wb(1, reg_ctrl, 4'hF, 32'h3);
        wb(0, reg_state, 4'hF, 0); chk(r, st_word(st_trickle, 0));
        chk({29'h0, trk, con, s_ln}, 32'h6);
        pre <= 1'b1;
        repeat (4) @(posedge clock);
        wb(0, reg_state, 4'hF, 0); chk(r, st_word(st_fast, 0));
        // done held back half to one and a half periods of 500 clocks
        eoc <= 1'b1;
        repeat (200) @(posedge clock);
        chk({31'h0, s_ln}, 32'h0);
        repeat (900) @(posedge clock);
        wb(0, reg_state, 4'hF, 0); chk(r, st_word(st_complete, 1));
        chk({29'h0, con, s_ln, irq}, 32'h7);
        wb(0, reg_irq_status, 4'hF, 0); chk(r, 32'h2);
        wb(1, reg_irq_status, 4'hF, 32'h2);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        blw <= 1'b1;
        repeat (200) @(posedge clock);
        chk({31'h0, s_ln}, 32'h1);
        repeat (600) @(posedge clock);
        chk({31'h0, s_ln}, 32'h0);
        wb(1, reg_irq_mask, 4'hF, 32'h0);
        tmp <= 1'b0;
        repeat (4) @(posedge clock);
        chk({29'h0, con, f_ln, irq}, 32'h0);
        wb(0, reg_irq_status, 4'hF, 0); chk(r, 32'hC);
        {tmp, pre, eoc, blw} <= 4'h8;
        wb(1, reg_ctrl, 4'hF, 32'h2);
        wb(0, reg_state, 4'hF, 0); chk(r, st_word(st_disabled, 0));
        ce = 2'h2;
        // random control writes, sel bit 0 gates the update
        repeat (6) begin
            d = $urandom;
            s = $urandom;
            wb(1, reg_ctrl, s[3:0], d);
            if (s[0]) ce = d[1:0];
            wb(0, reg_ctrl, 4'hF, 0); chk(r, {30'h0, ce});
            wb(0, reg_state, 4'hF, 0);
            chk(r, st_word(ce[0] ? st_trickle : st_disabled, 0));
        end
        summarize();
    end
endmodule
bind charge_cycle_sequencer charge_chk chk_i (.clock(clock), .reset_n(reset_n),
    .precond_reached(precond_reached), .temp_in_window(temp_in_window),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .charge_on(charge_on), .trickle_mode(trickle_mode),
    .status_oe(status_oe), .fault_oe(fault_oe), .status_o(status_o), .fault_o(fault_o));
